// ---- hw/dpwm_pkg.sv ----
/*
  Constants for the dual modulator block: register indices, field positions,
  reset values and sizes. Assumes the APB slave byte address is four times
  the register index, one register to an aligned 32-bit word.
*/
`default_nettype none

package dpwm_pkg;
  // ==========================================================================
  // sizes
  localparam int N_CHAN    = 2;
  localparam int N_TIMER   = 4;
  localparam int N_UNIT    = 5;
  localparam int APB_AW    = 16;
  localparam int APB_DW    = 32;
  localparam int IDX_W     = 12;
  localparam int DUTY_W    = 10;
  localparam int TMR_W     = 8;
  localparam int SUB_W     = 2;
  localparam int SEL_W     = 2;

  // ==========================================================================
  // register indices, byte address is index times four
  localparam logic [IDX_W-1:0] IDX_CHAN_B_DUTY   = 12'hF9F;
  localparam logic [IDX_W-1:0] IDX_CHAN_B_CTRL   = 12'hFA1;
  localparam logic [IDX_W-1:0] IDX_CHAN_A_DUTY   = 12'hFA2;
  localparam logic [IDX_W-1:0] IDX_CHAN_A_CTRL   = 12'hFA4;
  localparam logic [IDX_W-1:0] IDX_SEL_LOW       = 12'hFAD;
  localparam logic [IDX_W-1:0] IDX_SEL_HIGH      = 12'hFAE;
  localparam logic [IDX_W-1:0] IDX_SEL_EXTRA     = 12'hFAF;

  // ==========================================================================
  // control register fields
  localparam int CTL_EN_BIT  = 7;
  localparam int CTL_OUT_BIT = 5;
  localparam int CTL_POL_BIT = 4;

  // duty register fields
  localparam int DUTY_HI_MSB = 15;
  localparam int DUTY_HI_LSB = 8;
  localparam int DUTY_LO_MSB = 7;
  localparam int DUTY_LO_LSB = 6;

  // timer select fields (lsb positions)
  localparam int SEL_UNIT1_LSB = 0;
  localparam int SEL_UNIT4_LSB = 2;
  localparam int SEL_UNIT5_LSB = 0;
  localparam int SEL_CHA_LSB   = 2;
  localparam int SEL_CHB_LSB   = 4;
  localparam int SEL_UNIT2_LSB = 0;
  localparam int SEL_UNIT3_LSB = 2;

  // ==========================================================================
  // reset values
  localparam logic              CTL_RST   = 1'b0;
  localparam logic [SEL_W-1:0]  SEL_RST   = 2'h0;
  localparam logic [SUB_W-1:0]  SUB_RST   = 2'h0;

  // timer pair codes: 00 t1/t2, 01 t3/t4, 10 t5/t6, 11 t7/t8
  typedef enum logic [SEL_W-1:0] {
    DPWM_PAIR_T1_T2 = 2'b00,
    DPWM_PAIR_T3_T4 = 2'b01,
    DPWM_PAIR_T5_T6 = 2'b10,
    DPWM_PAIR_T7_T8 = 2'b11
  } dpwm_pair_t;
endpackage : dpwm_pkg

`default_nettype wire

// ---- hw/dpwm_chan_if.sv ----
/*
  Link between the register file and one modulator channel core.
  Assumes both ends share core_clk_i.
*/
`timescale 1ns/1ps
`default_nettype none

interface dpwm_chan_if;
  import dpwm_pkg::*;
  logic              en;
  logic              invert_output;
  logic [DUTY_W-1:0] duty;
  logic              level;
  modport regs (output en, output invert_output, output duty, input level);
  modport core (input en, input invert_output, input duty, output level);
endinterface : dpwm_chan_if

`default_nettype wire

// ---- hw/dpwm_timer_mux.sv ----
/*
  Picks one of the four 8-bit period timers for a channel.
  Assumes timer count, restart and tick inputs are synchronous to the clock.
*/
`timescale 1ns/1ps
`default_nettype none

module dpwm_timer_mux
  import dpwm_pkg::*;
(
  // timer bank
  input  wire logic [N_TIMER-1:0][TMR_W-1:0] count_i,
  input  wire logic [N_TIMER-1:0]            restart_i,
  input  wire logic [N_TIMER-1:0]            tick_i,
  // choice
  input  wire logic [SEL_W-1:0]              sel_i,
  // selected timer
  output logic      [TMR_W-1:0]              count_o,
  output logic                               restart_o,
  output logic                               tick_o
);
  // 00 timer 2, 01 timer 4, 10 timer 6, 11 timer 8
  always_comb begin
    count_o   = count_i[sel_i];
    restart_o = restart_i[sel_i];
    tick_o    = tick_i[sel_i];
  end
endmodule : dpwm_timer_mux

`default_nettype wire

// ---- hw/dpwm_channel.sv ----
/*
  One 10-bit modulator channel: duty buffer, time base, output flop.
  Assumes the selected timer gives a restart pulse on the increment after
  count equals its limit, and a tick per prescaled oscillator clock.
*/
`timescale 1ns/1ps
`default_nettype none

module dpwm_channel
  import dpwm_pkg::*;
(
  // clock and reset
  input  wire logic              core_clk_i,
  input  wire logic              reset_n_i,
  // selected timer
  input  wire logic [TMR_W-1:0]  count_i,
  input  wire logic              restart_i,
  input  wire logic              tick_i,
  // register side
  dpwm_chan_if.core              cfg
);
  logic [SUB_W-1:0]  sub;
  logic [DUTY_W-1:0] active_duty;
  logic              raw;
  logic              next_raw;
  logic              out_q;
  logic [DUTY_W-1:0] next_base;

  // ==========================================================================
  // low two bits of the time base
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sub <= SUB_RST;
    end else if (restart_i) begin
      sub <= SUB_RST;
    end else if (tick_i) begin
      sub <= sub + 2'h1;
    end
  end

  // ==========================================================================
  // active buffer: no reset so the value survives warm resets
  always_ff @(posedge core_clk_i) begin
    if (restart_i) begin
      active_duty <= cfg.duty;
    end
  end

  // look one tick ahead: the flop then falls as the base reaches the duty,
  // so a duty of d gives d base steps high, not d+1
  assign next_base = {count_i, sub} + 10'h001;

  always_comb begin
    next_raw = raw;
    if (!cfg.en) begin
      next_raw = 1'b0;
    end else if (restart_i) begin
      next_raw = (cfg.duty != '0);
    end else if (tick_i && (next_base == active_duty)) begin
      next_raw = 1'b0;
    end
  end

  // ==========================================================================
  // output flop carries polarity so read-back equals the driven level
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      raw   <= CTL_RST;
      out_q <= CTL_RST;
    end else begin
      raw   <= next_raw;
      out_q <= next_raw ^ cfg.invert_output;
    end
  end

  assign cfg.level = out_q;
endmodule : dpwm_channel

`default_nettype wire

// ---- hw/dpwm_top.sv ----
/*
  Dual 10-bit modulator with timer select registers, APB slave.
  Assumes the period timers and their prescaled ticks are outside; the
  capture/compare units only receive their timer pair choice.
*/
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module dpwm_top
  import dpwm_pkg::*;
(
  // clock and reset
  input  wire logic                                     core_clk_i,
  input  wire logic                                     reset_n_i,
  // apb slave
  input  wire logic                                     psel_i,
  input  wire logic                                     penable_i,
  input  wire logic                                     pwrite_i,
  input  wire logic [dpwm_pkg::APB_AW-1:0]              paddr_i,
  input  wire logic [dpwm_pkg::APB_DW-1:0]              pwdata_i,
  output logic      [dpwm_pkg::APB_DW-1:0]              prdata_o,
  output logic                                          pready_o,
  output logic                                          pslverr_o,
  // period timers
  input  wire logic [dpwm_pkg::N_TIMER-1:0][dpwm_pkg::TMR_W-1:0] period_timer_count_i,
  input  wire logic [dpwm_pkg::N_TIMER-1:0]             period_restart_i,
  input  wire logic [dpwm_pkg::N_TIMER-1:0]             timer_tick_i,
  // modulator outputs, index 0 channel a, 1 channel b
  output logic      [dpwm_pkg::N_CHAN-1:0]              pwm_out_o,
  // capture/compare unit timer pairs, index 0 unit1
  output logic      [dpwm_pkg::N_UNIT-1:0][dpwm_pkg::SEL_W-1:0] unit_timer_pair_o
);
  import dpwm_pkg::*;

  // ==========================================================================
  // register state
  logic [N_CHAN-1:0]              ctl_en;
  logic [N_CHAN-1:0]              ctl_pol;
  logic [N_CHAN-1:0][TMR_W-1:0]   duty_upper_byte;
  logic [N_CHAN-1:0][1:0]         duty_lower_pair;
  logic [N_CHAN-1:0][SEL_W-1:0]   chan_timer_choice;
  logic [N_UNIT-1:0][SEL_W-1:0]   unit_timer_choice;
  logic [N_CHAN-1:0]              level;

  // apb decode
  logic [IDX_W-1:0]  idx;
  logic              addr_ok;
  logic              setup;
  logic              wr_done;
  logic [APB_DW-1:0] next_rdata;
  logic              next_err;

  assign idx     = paddr_i[IDX_W+1:2];
  assign addr_ok = (paddr_i[APB_AW-1:IDX_W+2] == '0) && (paddr_i[1:0] == 2'h0);
  assign setup   = psel_i && !penable_i;
  assign wr_done = psel_i && penable_i && pready_o && pwrite_i && !pslverr_o;

  // ==========================================================================
  // read mux, evaluated in the setup cycle
  always_comb begin
    next_rdata = '0;
    next_err   = 1'b0;
    if (!addr_ok) begin
      next_err = 1'b1;
    end else begin
      case (idx)
        IDX_CHAN_A_CTRL, IDX_CHAN_B_CTRL: begin
          next_rdata[CTL_EN_BIT]  = ctl_en[idx == IDX_CHAN_B_CTRL];
          next_rdata[CTL_OUT_BIT] = level[idx == IDX_CHAN_B_CTRL];
          next_rdata[CTL_POL_BIT] = ctl_pol[idx == IDX_CHAN_B_CTRL];
        end
        IDX_CHAN_A_DUTY, IDX_CHAN_B_DUTY: begin
          next_rdata[DUTY_HI_MSB:DUTY_HI_LSB] = duty_upper_byte[idx == IDX_CHAN_B_DUTY];
          next_rdata[DUTY_LO_MSB:DUTY_LO_LSB] = duty_lower_pair[idx == IDX_CHAN_B_DUTY];
        end
        IDX_SEL_LOW: begin
          next_rdata[SEL_UNIT1_LSB+:SEL_W] = unit_timer_choice[0];
          next_rdata[SEL_UNIT4_LSB+:SEL_W] = unit_timer_choice[3];
        end
        IDX_SEL_HIGH: begin
          next_rdata[SEL_UNIT5_LSB+:SEL_W] = unit_timer_choice[4];
          next_rdata[SEL_CHA_LSB+:SEL_W]   = chan_timer_choice[0];
          next_rdata[SEL_CHB_LSB+:SEL_W]   = chan_timer_choice[1];
        end
        IDX_SEL_EXTRA: begin
          next_rdata[SEL_UNIT2_LSB+:SEL_W] = unit_timer_choice[1];
          next_rdata[SEL_UNIT3_LSB+:SEL_W] = unit_timer_choice[2];
        end
        default: begin
          next_err = 1'b1;
        end
      endcase
    end
  end

  // ==========================================================================
  // apb answer: ready rises in the first access cycle, never later
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= '0;
    end else if (setup) begin
      pready_o  <= 1'b1;
      pslverr_o <= next_err;
      prdata_o  <= pwrite_i ? '0 : next_rdata;
    end else begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
    end
  end

  // ==========================================================================
  // control registers
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ctl_en  <= '0;
      ctl_pol <= '0;
    end else if (wr_done) begin
      if (idx == IDX_CHAN_A_CTRL) begin
        ctl_en[0]  <= pwdata_i[CTL_EN_BIT];
        ctl_pol[0] <= pwdata_i[CTL_POL_BIT];
      end
      if (idx == IDX_CHAN_B_CTRL) begin
        ctl_en[1]  <= pwdata_i[CTL_EN_BIT];
        ctl_pol[1] <= pwdata_i[CTL_POL_BIT];
      end
    end
  end

  // ==========================================================================
  // duty registers: no reset, so warm resets leave them as written
  always_ff @(posedge core_clk_i) begin
    if (wr_done && idx == IDX_CHAN_A_DUTY) begin
      duty_upper_byte[0] <= pwdata_i[DUTY_HI_MSB:DUTY_HI_LSB];
      duty_lower_pair[0] <= pwdata_i[DUTY_LO_MSB:DUTY_LO_LSB];
    end
    if (wr_done && idx == IDX_CHAN_B_DUTY) begin
      duty_upper_byte[1] <= pwdata_i[DUTY_HI_MSB:DUTY_HI_LSB];
      duty_lower_pair[1] <= pwdata_i[DUTY_LO_MSB:DUTY_LO_LSB];
    end
  end

  // ==========================================================================
  // timer select registers
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      chan_timer_choice <= {N_CHAN{SEL_RST}};
      unit_timer_choice <= {N_UNIT{SEL_RST}};
    end else if (wr_done) begin
      case (idx)
        IDX_SEL_LOW: begin
          unit_timer_choice[0] <= pwdata_i[SEL_UNIT1_LSB+:SEL_W];
          unit_timer_choice[3] <= pwdata_i[SEL_UNIT4_LSB+:SEL_W];
        end
        IDX_SEL_HIGH: begin
          unit_timer_choice[4] <= pwdata_i[SEL_UNIT5_LSB+:SEL_W];
          chan_timer_choice[0] <= pwdata_i[SEL_CHA_LSB+:SEL_W];
          chan_timer_choice[1] <= pwdata_i[SEL_CHB_LSB+:SEL_W];
        end
        IDX_SEL_EXTRA: begin
          unit_timer_choice[1] <= pwdata_i[SEL_UNIT2_LSB+:SEL_W];
          unit_timer_choice[2] <= pwdata_i[SEL_UNIT3_LSB+:SEL_W];
        end
        default: begin
          chan_timer_choice <= chan_timer_choice;
        end
      endcase
    end
  end

  // pair code passes unchanged: the units decode 00 t1/t2 .. 11 t7/t8
  assign unit_timer_pair_o = unit_timer_choice;

  // ==========================================================================
  // channels
  genvar ch;
  generate
    for (ch = 0; ch < N_CHAN; ch++) begin : g_chan
      dpwm_chan_if cif ();
      logic [TMR_W-1:0] sel_count;
      logic             sel_restart;
      logic             sel_tick;

      assign cif.en   = ctl_en[ch];
      assign cif.invert_output  = ctl_pol[ch];
      assign cif.duty = {duty_upper_byte[ch], duty_lower_pair[ch]};
      assign level[ch]     = cif.level;
      assign pwm_out_o[ch] = cif.level;

      dpwm_timer_mux u_mux (
        .count_i   (period_timer_count_i),
        .restart_i (period_restart_i),
        .tick_i    (timer_tick_i),
        .sel_i     (chan_timer_choice[ch]),
        .count_o   (sel_count),
        .restart_o (sel_restart),
        .tick_o    (sel_tick)
      );

      dpwm_channel u_chan (
        .core_clk_i (core_clk_i),
        .reset_n_i  (reset_n_i),
        .count_i    (sel_count),
        .restart_i  (sel_restart),
        .tick_i     (sel_tick),
        .cfg        (cif.core)
      );
    end
  endgenerate
endmodule : dpwm_top

`default_nettype wire

// ---- test/dpwm_monitor.sv ----
/*
  Port checker for dpwm_top, bound into it.
  Assumes APB byte address is four times the register index.
*/
`timescale 1ns/1ps
`default_nettype none
module dpwm_monitor
  import dpwm_pkg::*;
(
  // clock and reset
  input wire logic                                     core_clk_i,
  input wire logic                                     reset_n_i,
  // apb
  input wire logic                                     psel_i,
  input wire logic                                     penable_i,
  input wire logic                                     pwrite_i,
  input wire logic [dpwm_pkg::APB_AW-1:0]              paddr_i,
  input wire logic [dpwm_pkg::APB_DW-1:0]              pwdata_i,
  input wire logic [dpwm_pkg::APB_DW-1:0]              prdata_o,
  input wire logic                                     pready_o,
  input wire logic                                     pslverr_o,
  // timers and outputs
  input wire logic [dpwm_pkg::N_TIMER-1:0][dpwm_pkg::TMR_W-1:0] period_timer_count_i,
  input wire logic [dpwm_pkg::N_TIMER-1:0]             period_restart_i,
  input wire logic [dpwm_pkg::N_TIMER-1:0]             timer_tick_i,
  input wire logic [dpwm_pkg::N_CHAN-1:0]              pwm_out_o,
  input wire logic [dpwm_pkg::N_UNIT-1:0][dpwm_pkg::SEL_W-1:0] unit_timer_pair_o
);
  localparam logic [APB_AW-1:0] A_LOW  = {2'b00, IDX_SEL_LOW, 2'b00};
  localparam logic [APB_AW-1:0] A_HIGH = {2'b00, IDX_SEL_HIGH, 2'b00};
  localparam logic [APB_AW-1:0] A_CTL  = {2'b00, IDX_CHAN_A_CTRL, 2'b00};
  localparam logic [APB_AW-1:0] A_DUTY = {2'b00, IDX_CHAN_A_DUTY, 2'b00};
  logic              wr_ok;
  logic              rd_set;
  logic              en_a;
  logic              pol_a;
  logic [1:0]        sel_a;
  logic [DUTY_W-1:0] duty_a;
  // ====
  // shadow of channel a settings
  assign wr_ok  = psel_i & penable_i & pwrite_i & pready_o & ~pslverr_o;
  assign rd_set = psel_i & ~penable_i & ~pwrite_i;
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      en_a  <= 1'b0;
      pol_a <= 1'b0;
      sel_a <= 2'h0;
    end else if (wr_ok && paddr_i == A_CTL) begin
      en_a  <= pwdata_i[7];
      pol_a <= pwdata_i[4];
    end else if (wr_ok && paddr_i == A_HIGH) begin
      sel_a <= pwdata_i[3:2];
    end
  end
  // not reset, like the duty register itself
  always_ff @(posedge core_clk_i) begin
    if (wr_ok && paddr_i == A_DUTY) begin
      duty_a <= {pwdata_i[15:8], pwdata_i[7:6]};
    end
  end
  // ====
  // assertions
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);
  AST_PREADY_ONE: assert property (psel_i && !penable_i |=> pready_o ##1 !pready_o)
    else $error("pready not a single pulse after setup");
  AST_SEL_LOW: assert property (wr_ok && paddr_i == A_LOW |-> ##2
    (unit_timer_pair_o[0] == $past(pwdata_i[1:0], 2)
     && unit_timer_pair_o[3] == $past(pwdata_i[3:2], 2)))
    else $error("unit1 or unit4 pair differs from written field");
  AST_SEL_HIGH: assert property (wr_ok && paddr_i == A_HIGH |-> ##2
    unit_timer_pair_o[4] == $past(pwdata_i[1:0], 2))
    else $error("unit5 pair differs from written field");
  AST_RESET_OUT: assert property ($rose(reset_n_i) |->
    pwm_out_o == '0 && unit_timer_pair_o == '0)
    else $error("outputs not cleared after reset");
  AST_CTL_READ: assert property (rd_set && paddr_i == A_CTL |=>
    prdata_o[5] == $past(pwm_out_o[0]) && prdata_o[7] == en_a
    && prdata_o[4] == pol_a && prdata_o[6] == 1'b0 && prdata_o[3:0] == 4'h0)
    else $error("control read back wrong");
  AST_DUTY_READ: assert property (rd_set && paddr_i == A_DUTY |=>
    prdata_o == {16'h0000, duty_a, 6'h00})
    else $error("duty read back wrong");
  AST_DISABLED: assert property (!en_a && $past(!en_a) && $stable(pol_a) |->
    pwm_out_o[0] == pol_a)
    else $error("disabled channel not at inactive level");
  AST_RESTART: assert property (en_a && !wr_ok && period_restart_i[sel_a] |=>
    pwm_out_o[0] == ((duty_a != '0) ^ pol_a))
    else $error("output wrong after period restart");
endmodule : dpwm_monitor
bind dpwm_top dpwm_monitor u_dpwm_monitor (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i),
  .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
  .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .period_timer_count_i(period_timer_count_i), .period_restart_i(period_restart_i),
  .timer_tick_i(timer_tick_i), .pwm_out_o(pwm_out_o), .unit_timer_pair_o(unit_timer_pair_o));
`default_nettype wire

// ---- test/dpwm_timer_model.sv ----
/*
  Period timer bank model for timers 2,4,6,8.
  Assumes one tick per clock; limit of index i is 3+i.
*/
`timescale 1ns/1ps
`default_nettype none
module dpwm_timer_model
  import dpwm_pkg::*;
(
  // clock and reset
  input  wire logic                                         core_clk_i,
  input  wire logic                                         reset_n_i,
  // timer bank
  output logic [dpwm_pkg::N_TIMER-1:0][dpwm_pkg::TMR_W-1:0] count_o,
  output logic [dpwm_pkg::N_TIMER-1:0]                      restart_o,
  output logic [dpwm_pkg::N_TIMER-1:0]                      tick_o
);
  logic [1:0] sub;
  // ====
  // distinct limits, so a wrong timer choice shows as a wrong width
  always_comb begin
    for (int i = 0; i < N_TIMER; i++) begin
      restart_o[i] = (sub == 2'h3) && (count_o[i] == 8'(3 + i));
    end
  end
  assign tick_o = '1;
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sub     <= 2'h0;
      count_o <= '0;
    end else begin
      sub <= sub + 2'h1;
      for (int i = 0; i < N_TIMER; i++) begin
        if (sub == 2'h3) begin
          count_o[i] <= restart_o[i] ? 8'h00 : count_o[i] + 8'h01;
        end
      end
    end
  end
endmodule : dpwm_timer_model
`default_nettype wire

// ---- test/test_dpwm_top.sv ----
/*
  Self-checking bench for dpwm_top over APB.
  Assumes dpwm_timer_model supplies the timers.
*/
`timescale 1ns/1ps
`default_nettype none
module test_dpwm_top;
  import dpwm_pkg::*;
  logic                          clk = 1'b0;
  logic                          rst_n = 1'b0;
  logic                          psel = 1'b0;
  logic                          penable = 1'b0;
  logic                          pwrite = 1'b0;
  logic [APB_AW-1:0]             paddr = '0;
  logic [APB_DW-1:0]             pwdata = '0;
  logic [APB_DW-1:0]             prdata;
  logic [APB_DW-1:0]             rd;
  logic                          pready;
  logic                          pslverr;
  logic                          err;
  logic [N_TIMER-1:0][TMR_W-1:0] cnt;
  logic [N_TIMER-1:0]            restart;
  logic [N_TIMER-1:0]            tick;
  logic [N_CHAN-1:0]             pwm;
  logic [N_UNIT-1:0][SEL_W-1:0]  pair;
  int                            n_mismatch = 0;
  int                            checks = 0;
  int                            hi;
  int                            dt[5] = '{0, 1, 15, 16, 1023};
  always #12.5 clk = ~clk;
  dpwm_timer_model u_dpwm_timer_model (.core_clk_i(clk), .reset_n_i(rst_n), .count_o(cnt),
    .restart_o(restart), .tick_o(tick));
  dpwm_top u_dpwm_top (.core_clk_i(clk), .reset_n_i(rst_n), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .period_timer_count_i(cnt),
    .period_restart_i(restart), .timer_tick_i(tick), .pwm_out_o(pwm), .unit_timer_pair_o(pair));
  // ====
  // helpers
  task automatic results();
    $display("mismatches %0d checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : results
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  function automatic logic [APB_AW-1:0] ad(input logic [IDX_W-1:0] idx);
    return {2'b00, idx, 2'b00};
  endfunction : ad
  task automatic apb(input logic w, input logic [APB_AW-1:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      n_mismatch++;
      results();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rdchk(input string nm, input logic [IDX_W-1:0] i, input logic [31:0] exp);
    apb(1'b0, ad(i), 32'h0);
    check(nm, rd, exp);
  endtask : rdchk
  // high cycles of one period, counted from a restart of timer t
  task automatic measure(input int t, input int ch);
    int n;
    n = 0;
    hi = 0;
    do begin
      @(negedge clk);
      n++;
    end while (restart[t] !== 1'b1 && n < 64);
    if (restart[t] !== 1'b1) begin
      n_mismatch++;
      results();
    end
    repeat (4 * (4 + t)) begin
      @(negedge clk);
      if (pwm[ch] === 1'b1) hi++;
    end
  endtask : measure
  task automatic run(input int ch, input int t, input int d, input logic invert_output);
    int p;
    int e;
    logic [IDX_W-1:0] ctl;
    p = 4 * (4 + t);
    e = (d < p) ? d : p;
    if (invert_output) e = p - e;
    ctl = ch ? IDX_CHAN_B_CTRL : IDX_CHAN_A_CTRL;
    apb(1'b1, ad(ch ? IDX_CHAN_B_DUTY : IDX_CHAN_A_DUTY), {16'h0, 10'(d), 6'h0});
    apb(1'b1, ad(ctl), {24'h0, 1'b1, 2'b0, invert_output, 4'h0});
    measure(t, ch);
    check("high cycles", 32'(hi), 32'(e));
    apb(1'b1, ad(ctl), {27'h0, invert_output, 4'h0});
    repeat (2) @(negedge clk);
    check("disabled level", 32'(pwm[ch]), 32'(invert_output));
  endtask : run
  // ====
  // main sequence
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rdchk("ctrl a", IDX_CHAN_A_CTRL, 32'h0);
    rdchk("ctrl b", IDX_CHAN_B_CTRL, 32'h0);
    rdchk("sel high", IDX_SEL_HIGH, 32'h0);
    check("pairs", 32'(pair), 32'h0);
    apb(1'b0, ad(12'hFA0), 32'h0);
    check("unmapped err", 32'(err), 32'h1);
    check("unmapped data", rd, 32'h0);
    apb(1'b1, ad(IDX_CHAN_A_CTRL) | 16'h0001, 32'h80);
    check("misaligned", 32'(err), 32'h1);
    rdchk("ctrl a dropped", IDX_CHAN_A_CTRL, 32'h0);
    apb(1'b1, ad(IDX_CHAN_A_DUTY), 32'hFFFFFFFF);
    rdchk("duty bits", IDX_CHAN_A_DUTY, 32'h0000FFC0);
    apb(1'b1, ad(IDX_CHAN_A_CTRL), 32'h20);
    rdchk("level ro", IDX_CHAN_A_CTRL, 32'h0);
    apb(1'b1, ad(IDX_CHAN_A_CTRL), 32'h10);
    rdchk("inv level", IDX_CHAN_A_CTRL, 32'h30);
    for (int c = 0; c < 4; c++) begin
      apb(1'b1, ad(IDX_SEL_LOW), 32'(c * 5));
      apb(1'b1, ad(IDX_SEL_HIGH), 32'(c * 21));
      rdchk("sel high rd", IDX_SEL_HIGH, 32'(c * 21));
      check("pairs", 32'(pair), 32'(c * 321));
    end
    apb(1'b1, ad(IDX_SEL_EXTRA), 32'h9);
    rdchk("sel extra rd", IDX_SEL_EXTRA, 32'h9);
    check("pairs extra", 32'(pair), 32'h3E7);
    apb(1'b1, ad(IDX_SEL_HIGH), 32'h0);
    foreach (dt[i]) begin
      for (int p = 0; p < 2; p++) run(0, 0, dt[i], p[0]);
    end
    for (int ch = 0; ch < 2; ch++) begin
      for (int k = 0; k < 4; k++) begin
        apb(1'b1, ad(IDX_SEL_HIGH), 32'(k) << (2 + 2 * ch));
        run(ch, k, 2 * k + 3, 1'b0);
      end
    end
    apb(1'b1, ad(IDX_CHAN_A_DUTY), 32'h12345678);
    apb(1'b1, ad(IDX_CHAN_A_CTRL), 32'h90);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    check("out after reset", 32'(pwm), 32'h0);
    rdchk("duty kept", IDX_CHAN_A_DUTY, 32'h00005640);
    rdchk("ctrl cleared", IDX_CHAN_A_CTRL, 32'h0);
    results();
  end
endmodule : test_dpwm_top
`default_nettype wire
